// ===== logic/bsp_defines.svh
// register map, reset values, codes and rates of the serial port engine
`ifndef BSP_DEFINES_SVH
`define BSP_DEFINES_SVH
`define BSP_OFS_CTRL   16'h0000
`define BSP_OFS_RXBASE 16'h0004
`define BSP_OFS_RXCAP  16'h0008
`define BSP_OFS_CMD    16'h000c
`define BSP_OFS_STAT   16'h0010
`define BSP_OFS_MEM    16'h4000
`define BSP_CTRL_RST   32'h000d0034
`define BSP_RXBASE_RST 16'h0000
`define BSP_CHAR_STX   8'h02
`define BSP_TX_MAX     16'h0800
`define BSP_RX_MAX     13'h1000
`define BSP_CLK_HZ     32'h0bebc200
`define BSP_RATE_2400  32'h00000960
`define BSP_RATE_4800  32'h000012c0
`define BSP_RATE_9600  32'h00002580
`define BSP_RATE_19200 32'h00004b00
`define BSP_RATE_38400 32'h00009600
`define BSP_RATE_57600 32'h0000e100
`define BSP_RATE_115K  32'h0001c200
`define BSP_RESP_OKAY  2'h0
`define BSP_RESP_ERR   2'h2
`endif

// ===== logic/bsp_pkg.sv
// types shared by the serial port engine files
package bsp_pkg;
   typedef struct packed {
      logic [7:0] rsv_hi;
      logic [7:0] term;
      logic [6:0] rsv;
      logic       hdr;
      logic       stop2;
      logic [1:0] par;
      logic       len8;
      logic [2:0] baud;
      logic       gen;
   } bsp_ctrl_t;
   typedef struct packed {
      logic [2:0] baud;
      logic       len8;
      logic [1:0] par;
      logic       stop2;
   } bsp_fmt_t;
   typedef enum logic [2:0] {
      SEL_CTRL, SEL_RXBASE, SEL_RXCAP, SEL_CMD, SEL_STAT, SEL_MEM, SEL_BAD
   } bsp_sel_t;
   typedef enum logic [2:0] {
      TX_IDLE, TX_HDR, TX_DATA, TX_TERM, TX_FIN
   } bsp_txst_t;
endpackage

// ===== logic/bsp_serial_char.sv
// one-character serial transmitter and receiver with baud divider
`timescale 1ns/100ps
`include "bsp_defines.svh"
module bsp_serial_char
   import bsp_pkg::*;
#(
   parameter int CLK_HZ = `BSP_CLK_HZ
)(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire bsp_fmt_t   fmt,
   input  wire logic       tx_go,
   input  wire logic [7:0] tx_byte,
   output logic            tx_busy,
   output logic            txd,
   input  wire logic       rxd,
   output logic            rx_stb,
   output logic [7:0]      rx_byte,
   output logic            rx_perr
);
   // R22 rate divider
   function automatic logic [17:0] divisor(input logic [2:0] sel);
      logic [31:0] rate;
      case (sel)
         3'h0: rate = `BSP_RATE_2400;
         3'h1: rate = `BSP_RATE_4800;
         3'h3: rate = `BSP_RATE_19200;
         3'h4: rate = `BSP_RATE_38400;
         3'h5: rate = `BSP_RATE_57600;
         3'h6: rate = `BSP_RATE_115K;
         default: rate = `BSP_RATE_9600;
      endcase
      divisor = 18'(CLK_HZ / rate);
   endfunction

   logic [17:0] div, tx_cnt_r, rx_cnt_r;
   logic [11:0] frm, tx_sh_r;
   logic [3:0]  nb, tx_nb_r, rx_k, rx_idx_r;
   logic [8:0]  rx_sh_r, rx_al;
   logic [7:0]  rx_d;
   logic        tx_busy_r, par_b, rx_s1_r, rx_s2_r, rx_on_r, rx_pbad;
   logic        rx_stb_r, rx_perr_r;
   logic [7:0]  rx_byte_r;

   assign div = divisor(fmt.baud);
   assign tx_busy = tx_busy_r;
   assign txd = tx_sh_r[0];
   assign rx_stb = rx_stb_r;
   assign rx_byte = rx_byte_r;
   assign rx_perr = rx_perr_r;

   // R18 frame layout
   always_comb
   begin
      frm = 12'hfff;
      par_b = (fmt.par == 2'h1) ? ~^tx_byte[6:0] ^ (fmt.len8 & tx_byte[7])
                                : ^tx_byte[6:0] ^ (fmt.len8 & tx_byte[7]);
      frm[0] = 1'b0;
      if (fmt.len8)
         frm[8:1] = tx_byte;
      else
         frm[7:1] = tx_byte[6:0];
      nb = fmt.len8 ? 4'h9 : 4'h8;
      if (fmt.par != 2'h0)
      begin
         frm[nb] = par_b;
         nb = nb + 4'h1;
      end
      nb = nb + (fmt.stop2 ? 4'h2 : 4'h1);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_sh_r <= 12'hfff;
         tx_nb_r <= 4'h0;
         tx_cnt_r <= 18'h0;
         tx_busy_r <= 1'b0;
      end
      else if (!tx_busy_r)
      begin
         if (tx_go)
         begin
            tx_sh_r <= frm;
            tx_nb_r <= nb;
            tx_cnt_r <= div - 18'h1;
            tx_busy_r <= 1'b1;
         end
      end
      else if (tx_cnt_r == 18'h0)
      begin
         tx_cnt_r <= div - 18'h1;
         tx_sh_r <= {1'b1, tx_sh_r[11:1]};
         tx_nb_r <= tx_nb_r - 4'h1;
         tx_busy_r <= (tx_nb_r != 4'h1);
      end
      else
         tx_cnt_r <= tx_cnt_r - 18'h1;
   end

   // receiver: data bits plus parity, then stop
   assign rx_k = (fmt.len8 ? 4'h8 : 4'h7) + {3'h0, fmt.par != 2'h0};
   assign rx_al = rx_sh_r >> (4'h9 - rx_k);
   assign rx_d = fmt.len8 ? rx_al[7:0] : {1'b0, rx_al[6:0]};
   assign rx_pbad = (fmt.par != 2'h0) &&
      ((^{rx_d, rx_al[fmt.len8 ? 8 : 7]}) != (fmt.par == 2'h1));

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
      end
      else
      begin
         rx_s1_r <= rxd;
         rx_s2_r <= rx_s1_r;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_on_r <= 1'b0;
         rx_cnt_r <= 18'h0;
         rx_idx_r <= 4'h0;
         rx_sh_r <= 9'h0;
         rx_stb_r <= 1'b0;
         rx_byte_r <= 8'h0;
         rx_perr_r <= 1'b0;
      end
      else
      begin
         rx_stb_r <= 1'b0;
         if (!rx_on_r)
         begin
            rx_on_r <= !rx_s2_r;
            rx_cnt_r <= {1'b0, div[17:1]};
            rx_idx_r <= 4'h0;
         end
         else if (rx_cnt_r != 18'h0)
            rx_cnt_r <= rx_cnt_r - 18'h1;
         else
         begin
            rx_cnt_r <= div - 18'h1;
            rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_idx_r == 4'h0)
               rx_on_r <= !rx_s2_r;
            else if (rx_idx_r <= rx_k)
               rx_sh_r <= {rx_s2_r, rx_sh_r[8:1]};
            else
            begin
               rx_on_r <= 1'b0;
               rx_stb_r <= 1'b1;
               rx_byte_r <= rx_d;
               rx_perr_r <= rx_pbad | !rx_s2_r;
            end
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_tx_start_bit: assert property (tx_go && !tx_busy |=> !txd) // R1
      else $error("start bit not driven after go");
   a_tx_idle_line: assert property (!tx_busy |-> txd) // R18
      else $error("line not idle high");
endmodule // bsp_serial_char

// ===== logic/bsp_engine.sv
// buffered serial port engine with AXI4-Lite registers and data words
// Functional notes
// R1: transfer command sends requested send-buffer bytes
// R2: terminator appended after every sent block
// R3: at most 2048 payload bytes per send
// R4: at most 4096 received bytes stored
// R5: terminator never stored in receive buffer
// R6: receive only while reception-done clear
// R7: seven bit rates, 9600 after reset
// R8: host-link mode after reset, general selectable
// R9: receive buffer base and size configurable
// R10: start stores count, clears rx flag, count
// R11: payload from base+1, low byte first
// R12: transmission-done low while sending
// R13: optional STX header sent first
// R14: after send, count word zeroed, done set
// R15: terminator sets rx done, blocks reception
// R16: zero count sends nothing, rearms reception
// R17: program uses port 1/2, data words
// R18: 7/8 bits, none/odd/even, 1/2 stops
// R19: STX is 02; mid-data STX restarts
// R20: received count in first buffer word
// R21: overflow bytes dropped inside buffer
// R22: bit timing divided from system clock
`timescale 1ns/100ps
`include "bsp_defines.svh"
module bsp_engine
   import bsp_pkg::*;
#(
   parameter int DATA_WORDS = 1024,
   parameter int CLK_HZ     = `BSP_CLK_HZ
)(
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic [15:0] S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [15:0] S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   input  wire logic        RXD,
   output logic             TXD
);
   localparam int AW = $clog2(DATA_WORDS);
   localparam logic [15:0] WORDS = 16'(DATA_WORDS);

   if (DATA_WORDS < 4 || DATA_WORDS > 4096 ||
       (1 << AW) != DATA_WORDS)
   begin : g_bad_words
      $error("DATA_WORDS must be a power of two from 4 to 4096");
   end
   if (CLK_HZ / 115200 < 4)
   begin : g_bad_clk
      $error("CLK_HZ too low for the fastest bit rate");
   end

   // ****************************************
   // address decode and byte merge
   // ****************************************
   function automatic bsp_sel_t dec(input logic [15:0] a);
      if (a[1:0] != 2'h0)
         return SEL_BAD;
      if (a >= `BSP_OFS_MEM && a < `BSP_OFS_MEM + 16'(DATA_WORDS * 4))
         return SEL_MEM;
      case (a)
         `BSP_OFS_CTRL:   return SEL_CTRL;
         `BSP_OFS_RXBASE: return SEL_RXBASE;
         `BSP_OFS_RXCAP:  return SEL_RXCAP;
         `BSP_OFS_CMD:    return SEL_CMD;
         `BSP_OFS_STAT:   return SEL_STAT;
         default:         return SEL_BAD;
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0]  s);
      for (int i = 0; i < 4; i++)
         merge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
   endfunction

   logic            aw_full_r, w_full_r, bvalid_r, rvalid_r;
   logic [15:0]     awaddr_r;
   logic [31:0]     wdata_r, rdata_r, rd_val, wr_cur, wr_val;
   logic [3:0]      wstrb_r;
   logic [1:0]      bresp_r, rresp_r;
   bsp_ctrl_t       ctrl_r;
   logic [15:0]     rxbase_r, rxcap_r, tx_base_r, cmd_n, cmd_base;
   logic [12:0]     rx_cnt_r, rx_cnt_nxt;
   logic            tx_done_r, rx_done_r, err_r;
   bsp_txst_t       tx_st_r, tx_st_nxt;
   logic [11:0]     tx_ptr_r, tx_n_r;
   logic [15:0]     mem [DATA_WORDS];
   bsp_sel_t        wsel, rsel;
   logic [AW-1:0]   aw_idx, ar_idx, tx_widx, rx_widx;
   logic [15:0]     tx_word;
   logic            wr_go, w_cmd, cmd_ok, cmd_go, wr_bad, tx_end;
   logic            ch_busy, ch_go, rx_stb, rx_perr;
   logic [7:0]      ch_byte, rx_byte;
   logic            rx_take, rx_stx, rx_term, rx_room, rx_store;
   bsp_fmt_t        fmt;

   // ****************************************
   // AXI4-Lite write channel
   // ****************************************
   assign S_AXI_AWREADY = !aw_full_r;
   assign S_AXI_WREADY = !w_full_r;
   assign S_AXI_BVALID = bvalid_r;
   assign S_AXI_BRESP = bresp_r;
   assign wr_go = aw_full_r && w_full_r && !bvalid_r;
   assign wsel = dec(awaddr_r);
   assign aw_idx = awaddr_r[AW+1:2];
   assign wr_cur = (wsel == SEL_CTRL)   ? ctrl_r :
                   (wsel == SEL_RXBASE) ? {16'h0, rxbase_r} :
                   (wsel == SEL_RXCAP)  ? {16'h0, rxcap_r} :
                   (wsel == SEL_MEM)    ? {16'h0, mem[aw_idx]} : 32'h0;
   assign wr_val = merge(wr_cur, wdata_r, wstrb_r);
   assign cmd_n = wdata_r[15:0];
   assign cmd_base = wdata_r[31:16];
   assign w_cmd = wr_go && (wsel == SEL_CMD);
   // R3 count limit
   assign cmd_ok = ctrl_r.gen && tx_done_r && (cmd_n <= `BSP_TX_MAX) &&
                   (cmd_base < WORDS);
   assign cmd_go = w_cmd && cmd_ok;
   assign wr_bad = (wsel == SEL_BAD) || (wsel == SEL_STAT) ||
                   (wsel == SEL_CMD && !cmd_ok) ||
                   (wsel == SEL_RXBASE && wr_val[15:0] >= WORDS);

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `BSP_RESP_OKAY;
         awaddr_r <= 16'h0;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
      end
      else
      begin
         if (S_AXI_AWVALID && !aw_full_r)
         begin
            aw_full_r <= 1'b1;
            awaddr_r <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && !w_full_r)
         begin
            w_full_r <= 1'b1;
            wdata_r <= S_AXI_WDATA;
            wstrb_r <= S_AXI_WSTRB;
         end
         if (wr_go)
         begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_bad ? `BSP_RESP_ERR : `BSP_RESP_OKAY;
         end
         else if (S_AXI_BREADY)
            bvalid_r <= 1'b0;
      end
   end

   // R7 R8 R9 configuration
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         ctrl_r <= `BSP_CTRL_RST;
         rxbase_r <= `BSP_RXBASE_RST;
         rxcap_r <= WORDS;
      end
      else if (wr_go && !wr_bad)
      begin
         if (wsel == SEL_CTRL)
            ctrl_r <= wr_val & 32'h00ff01ff;
         if (wsel == SEL_RXBASE)
            rxbase_r <= wr_val[15:0];
         if (wsel == SEL_RXCAP)
            rxcap_r <= wr_val[15:0];
      end
   end

   // ****************************************
   // AXI4-Lite read channel
   // ****************************************
   assign S_AXI_ARREADY = !rvalid_r;
   assign S_AXI_RVALID = rvalid_r;
   assign S_AXI_RDATA = rdata_r;
   assign S_AXI_RRESP = rresp_r;
   assign rsel = dec(S_AXI_ARADDR);
   assign ar_idx = S_AXI_ARADDR[AW+1:2];
   assign rd_val = (rsel == SEL_CTRL)   ? ctrl_r :
                   (rsel == SEL_RXBASE) ? {16'h0, rxbase_r} :
                   (rsel == SEL_RXCAP)  ? {16'h0, rxcap_r} :
                   (rsel == SEL_STAT)   ? {3'h0, rx_cnt_r, 13'h0, err_r,
                                           rx_done_r, tx_done_r} :
                   (rsel == SEL_MEM)    ? {16'h0, mem[ar_idx]} : 32'h0;

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= `BSP_RESP_OKAY;
      end
      else if (S_AXI_ARVALID && !rvalid_r)
      begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_val;
         rresp_r <= (rsel == SEL_BAD) ? `BSP_RESP_ERR : `BSP_RESP_OKAY;
      end
      else if (S_AXI_RREADY)
         rvalid_r <= 1'b0;
   end

   // ****************************************
   // send engine
   // ****************************************
   // R11 word and byte order
   assign tx_widx = AW'(tx_base_r + 16'h1 + {5'h0, tx_ptr_r[11:1]});
   assign tx_word = mem[tx_widx];
   // R13 R2 header, payload, terminator
   assign ch_byte = (tx_st_r == TX_HDR)  ? `BSP_CHAR_STX :
                    (tx_st_r == TX_TERM) ? ctrl_r.term :
                    tx_ptr_r[0] ? tx_word[15:8] : tx_word[7:0];
   assign ch_go = !ch_busy && (tx_st_r == TX_HDR || tx_st_r == TX_DATA ||
                               tx_st_r == TX_TERM);
   assign tx_end = (tx_st_r == TX_FIN) && !ch_busy;

   // R1 R16 send sequence
   always_comb
   begin
      tx_st_nxt = tx_st_r;
      case (tx_st_r)
         TX_IDLE: if (cmd_go && cmd_n != 16'h0)
                     tx_st_nxt = ctrl_r.hdr ? TX_HDR : TX_DATA;
         TX_HDR:  if (ch_go) tx_st_nxt = TX_DATA;
         TX_DATA: if (ch_go && tx_ptr_r == tx_n_r - 12'h1)
                     tx_st_nxt = TX_TERM;
         TX_TERM: if (ch_go) tx_st_nxt = TX_FIN;
         TX_FIN:  if (!ch_busy) tx_st_nxt = TX_IDLE;
         default: tx_st_nxt = TX_IDLE;
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         tx_st_r <= TX_IDLE;
         tx_done_r <= 1'b1;
         tx_ptr_r <= 12'h0;
         tx_n_r <= 12'h0;
         tx_base_r <= 16'h0;
      end
      else
      begin
         tx_st_r <= tx_st_nxt;
         if (cmd_go)
         begin
            tx_ptr_r <= 12'h0;
            tx_n_r <= cmd_n[11:0];
            tx_base_r <= cmd_base;
         end
         else if (ch_go && tx_st_r == TX_DATA)
            tx_ptr_r <= tx_ptr_r + 12'h1;
         // R12 R14 done flag
         if (cmd_go && cmd_n != 16'h0)
            tx_done_r <= 1'b0;
         else if (tx_end)
            tx_done_r <= 1'b1;
      end
   end

   // ****************************************
   // receive engine
   // ****************************************
   // R6 R8 reception gate
   assign rx_take = rx_stb && ctrl_r.gen && !rx_done_r;
   assign rx_stx = (rx_byte == `BSP_CHAR_STX);
   assign rx_term = rx_take && (rx_byte == ctrl_r.term);
   // R4 R21 room left
   assign rx_room = (rxcap_r != 16'h0) && (rx_cnt_r < `BSP_RX_MAX) &&
                    ({4'h0, rx_cnt_r} < {rxcap_r - 16'h1, 1'b0});
   // R5 terminator and header not stored
   assign rx_store = rx_take && !rx_stx && !rx_term && rx_room;
   assign rx_widx = AW'(rxbase_r + 16'h1 + {4'h0, rx_cnt_r[12:1]});
   // R10 R19 count clear and restart
   assign rx_cnt_nxt = (cmd_go || (rx_take && rx_stx)) ? 13'h0 :
                       rx_store ? rx_cnt_r + 13'h1 : rx_cnt_r;

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rx_cnt_r <= 13'h0;
         rx_done_r <= 1'b0;
         err_r <= 1'b0;
      end
      else
      begin
         rx_cnt_r <= rx_cnt_nxt;
         // R15 R16 rx done, set wins
         if (rx_term)
            rx_done_r <= 1'b1;
         else if (cmd_go)
            rx_done_r <= 1'b0;
         if (rx_take && rx_perr)
            err_r <= 1'b1;
         else if (cmd_go)
            err_r <= 1'b0;
      end
   end

   // ****************************************
   // data word memory
   // ****************************************
   always_ff @(posedge CLK)
   begin
      if (wr_go && wsel == SEL_MEM)
         mem[aw_idx] <= wr_val[15:0];
      // R10 count into send base
      if (cmd_go)
         mem[AW'(cmd_base)] <= cmd_n;
      // R14 clear send count
      if (tx_end)
         mem[AW'(tx_base_r)] <= 16'h0;
      if (rx_store && rx_cnt_r[0])
         mem[rx_widx][15:8] <= rx_byte;
      if (rx_store && !rx_cnt_r[0])
         mem[rx_widx][7:0] <= rx_byte;
      // R20 count word
      if (rx_take || cmd_go)
         mem[AW'(rxbase_r)] <= {3'h0, rx_cnt_nxt};
   end

   assign fmt = '{baud: ctrl_r.baud, len8: ctrl_r.len8, par: ctrl_r.par,
                  stop2: ctrl_r.stop2};

   bsp_serial_char #(.CLK_HZ(CLK_HZ)) u_char (
      .clk     (CLK),
      .rst_n   (RST_N),
      .fmt     (fmt),
      .tx_go   (ch_go),
      .tx_byte (ch_byte),
      .tx_busy (ch_busy),
      .txd     (TXD),
      .rxd     (RXD),
      .rx_stb  (rx_stb),
      .rx_byte (rx_byte),
      .rx_perr (rx_perr)
   );

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence s_cmd_start;
      cmd_go && cmd_n != 16'h0;
   endsequence

   a_busy_not_done: assert property (tx_st_r != TX_IDLE |-> !tx_done_r) // R12
      else $error("done flag high during send");
   a_start_clears: assert property (cmd_go && !rx_term |=> // R10
      !rx_done_r && rx_cnt_r == 13'h0)
      else $error("command did not rearm reception");
   a_send_ends: assert property (tx_end |=> tx_done_r && // R14
      mem[AW'($past(tx_base_r))] == 16'h0)
      else $error("send end did not set done");
   a_rx_blocked: assert property (rx_done_r && !cmd_go |=> // R6
      $stable(rx_cnt_r))
      else $error("count moved while reception done");
   a_rx_limit: assert property (rx_cnt_r <= `BSP_RX_MAX) // R4
      else $error("receive count beyond limit");
   a_term_done: assert property (rx_term |=> rx_done_r) // R15
      else $error("terminator did not set done");
   a_stx_restart: assert property (rx_take && rx_stx && !cmd_go // R19
      |=> rx_cnt_r == 13'h0)
      else $error("header did not restart count");
   a_cmd_limit: assert property (w_cmd && cmd_n > `BSP_TX_MAX |=> // R3
      S_AXI_BVALID && S_AXI_BRESP == `BSP_RESP_ERR)
      else $error("oversized send accepted");
   a_hdr_first: assert property (s_cmd_start ##1 ctrl_r.hdr // R13
      |-> tx_st_r == TX_HDR)
      else $error("header not sent first");
   a_zero_no_send: assert property (cmd_go && cmd_n == 16'h0 // R16
      |=> tx_st_r == TX_IDLE && tx_done_r)
      else $error("zero count started a send");
endmodule // bsp_engine

// ===== verification/bsp_dev_model.sv
// serial device model facing the port engine, 8 bits, no parity, 1 stop
`timescale 1ns/100ps
module bsp_dev_model
(
   input  wire logic clk,
   input  wire logic txd,
   output logic      rxd
);
   int         bit_cyc = 120;
   logic [7:0] got[$];
   logic [7:0] sh;
   initial rxd = 1'b1;
   // ******
   // capture
   // ******
   always
   begin
      @(negedge txd);
      repeat (bit_cyc / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (bit_cyc) @(posedge clk);
         sh[i] = txd;
      end
      repeat (bit_cyc) @(posedge clk);
      got.push_back(sh);
   end
   // line idles high once the stop bit ends
   task automatic send(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         rxd <= f[i];
         repeat (bit_cyc) @(posedge clk);
      end
   endtask
endmodule // bsp_dev_model

// ===== verification/bsp_engine_tb.sv
// self-checking bench of the buffered serial port engine
`timescale 1ns/100ps
`include "bsp_defines.svh"
module bsp_engine_tb;
   localparam int CK = 1152000;
   localparam int DW = 64;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [15:0] awaddr = '0;
   logic [15:0] araddr = '0;
   logic [31:0] wdata = '0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        arvalid = 1'b0;
   logic        bready = 1'b0;
   logic        rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, txd, rxd;
   logic [1:0]  bresp, rresp, rsp;
   logic [31:0] rdata, rdat;
   logic [7:0]  pay[$];
   int          n_mismatch = 0;
   int          num_checks = 0;
   int          seed;
   logic [31:0] rates[7] = '{`BSP_RATE_2400, `BSP_RATE_4800,
      `BSP_RATE_9600, `BSP_RATE_19200, `BSP_RATE_38400, `BSP_RATE_57600,
      `BSP_RATE_115K};

   always #2.5 clk = ~clk;

   bsp_engine #(.DATA_WORDS(DW), .CLK_HZ(CK)) u_dut (
      .CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .RXD(rxd), .TXD(txd));
   bsp_dev_model u_dev (.clk(clk), .txd(txd), .rxd(rxd));

   // ******
   // tasks
   // ******
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("MISMATCH %0t seen %h want %h", $time, s, e);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      d = rdata;
      rsp = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask
   function automatic logic [15:0] ma(input int w);
      return 16'(`BSP_OFS_MEM + 4 * w);
   endfunction
   function automatic logic [31:0] ctrl_of(input int r, input logic h);
      return {8'h00, 8'h0d, 7'h00, h, 4'h1, r[2:0], 1'b1};
   endfunction
   task automatic send_blk(input int base, input int n, input logic h);
      logic [15:0] w;
      pay.delete();
      u_dev.got.delete();
      for (int j = 0; j < n; j += 2)
      begin
         w = 16'($urandom);
         wr(ma(base + 1 + j / 2), {16'h0000, w});
         pay.push_back(w[7:0]);
         if (j + 1 < n) pay.push_back(w[15:8]);
      end
      if (h) pay.push_front(`BSP_CHAR_STX);
      pay.push_back(8'h0d);
      wr(`BSP_OFS_CMD, {16'(base), 16'(n)});
      rd(ma(base), rdat);
      chk(rdat, 32'(n));
      rd(`BSP_OFS_STAT, rdat);
      chk(rdat[0], 1'b0);
      wr(`BSP_OFS_CMD, {16'(base), 16'(n)});
      chk(rsp, `BSP_RESP_ERR);
      do rd(`BSP_OFS_STAT, rdat);
      while (rdat[0] !== 1'b1);
      chk(u_dev.got.size(), pay.size());
      foreach (pay[j]) chk(u_dev.got[j], pay[j]);
      rd(ma(base), rdat);
      chk(rdat, 32'h0);
   endtask
   task automatic rx_blk(input int n);
      logic [7:0] b;
      pay.delete();
      u_dev.send(`BSP_CHAR_STX);
      for (int j = 0; j < n; j++)
      begin
         b = 8'($urandom);
         if (b == 8'h02 || b == 8'h0d) b = 8'h41;
         pay.push_back(b);
         u_dev.send(b);
      end
      u_dev.send(8'h0d);
      repeat (4) @(posedge clk);
   endtask

   // ******
   // tests
   // ******
   initial
   begin
      seed = $urandom(32'hd235);
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(`BSP_OFS_CTRL, rdat);
      chk(rdat, `BSP_CTRL_RST);
      rd(`BSP_OFS_RXCAP, rdat);
      chk(rdat, 32'(DW));
      rd(16'h0100, rdat);
      chk(rsp, `BSP_RESP_ERR);
      wr(`BSP_OFS_CMD, 32'h00080001);
      chk(rsp, `BSP_RESP_ERR);
      for (int r = 0; r < 7; r++)
      begin
         wr(`BSP_OFS_CTRL, ctrl_of(r, r[0]));
         rd(`BSP_OFS_CTRL, rdat);
         chk(rdat, ctrl_of(r, r[0]));
         u_dev.bit_cyc = CK / rates[r];
         send_blk(8, 1 + $urandom % 3, r[0]);
      end
      wr(`BSP_OFS_CMD, 32'h00080801);
      chk(rsp, `BSP_RESP_ERR);
      wr(`BSP_OFS_RXBASE, 32'h00000020);
      wr(`BSP_OFS_RXCAP, 32'h00000004);
      wr(ma(36), 32'h00001234);
      u_dev.send(8'haa);
      rx_blk(8);
      rd(`BSP_OFS_STAT, rdat);
      chk(rdat, 32'h00060003);
      rd(ma(32), rdat);
      chk(rdat, 32'h00000006);
      for (int j = 0; j < 3; j++)
      begin
         rd(ma(33 + j), rdat);
         chk(rdat, {16'h0000, pay[2 * j + 1], pay[2 * j]});
      end
      rd(ma(36), rdat);
      chk(rdat, 32'h00001234);
      u_dev.send(8'h55);
      rd(`BSP_OFS_STAT, rdat);
      chk(rdat, 32'h00060003);
      wr(`BSP_OFS_CMD, 32'h00080000);
      chk(rsp, `BSP_RESP_OKAY);
      rd(`BSP_OFS_STAT, rdat);
      chk(rdat, 32'h00000001);
      rx_blk(2);
      rd(`BSP_OFS_STAT, rdat);
      chk(rdat, 32'h00020003);
      rd(ma(33), rdat);
      chk(rdat, {16'h0000, pay[1], pay[0]});
      results();
   end

   initial
   begin
      #500000;
      n_mismatch++;
      results();
   end
endmodule // bsp_engine_tb
